// ### ebl_pkg.sv
// constants, layouts and state encodings shared by the boot loader files
package ebl_pkg;

  localparam int unsigned IDX_W = 11;
  localparam int unsigned QW = 12;
  localparam int unsigned EE_MAX_BYTES = 2048;

  // open-drain bus addressing of the boot memory
  localparam logic [7:0] EE_DEV_WRITE = 8'ha0;
  localparam logic [7:0] EE_DEV_READ = 8'ha1;
  localparam logic [7:0] EE_WORD_START = 8'h00;

  // byte positions in the boot memory image
  localparam logic [IDX_W-1:0] IDX_CFG = 11'h000;
  localparam logic [IDX_W-1:0] IDX_SUBSYS_HI = 11'h001;
  localparam logic [IDX_W-1:0] IDX_SUBSYS_LO = 11'h002;
  localparam logic [IDX_W-1:0] IDX_VENDOR_HI = 11'h003;
  localparam logic [IDX_W-1:0] IDX_VENDOR_LO = 11'h004;
  localparam logic [IDX_W-1:0] IDX_MMI_HI = 11'h005;
  localparam logic [IDX_W-1:0] IDX_MMI_MID = 11'h006;
  localparam logic [IDX_W-1:0] IDX_MMI_LO = 11'h007;
  localparam logic [IDX_W-1:0] IDX_PLL = 11'h008;
  localparam logic [IDX_W-1:0] IDX_MODE = 11'h009;
  localparam logic [IDX_W-1:0] IDX_HOST_LAST = 11'h00a;
  localparam logic [IDX_W-1:0] IDX_DBASE = 11'h00a;
  localparam logic [IDX_W-1:0] IDX_IOBASE = 11'h00e;
  localparam logic [IDX_W-1:0] IDX_LEN_HI = 11'h012;
  localparam logic [IDX_W-1:0] IDX_LEN_LO = 11'h013;
  localparam logic [IDX_W-1:0] IDX_PROG = 11'h014;
  localparam logic [IDX_W-1:0] IDX_CAP_SMALL = 11'h07f;
  localparam logic [IDX_W-1:0] IDX_CAP_LARGE = 11'h7ff;

  // fields of the first byte and of the mode byte
  localparam int unsigned CFG_LINES_BIT = 7;
  localparam int unsigned CFG_APER_LSB = 4;
  localparam int unsigned CFG_CLK_LSB = 2;
  localparam int unsigned CFG_FAST_BIT = 1;
  localparam int unsigned CFG_TEST_BIT = 0;
  localparam int unsigned MODE_AUTO_BIT = 7;

  // serial clock generation, four quarter phases per bit
  localparam int unsigned QUARTERS = 4;
  localparam int unsigned SLOW_DIVIDE = 1000;
  localparam logic [QW-1:0] SLOW_QUARTER = QW'(SLOW_DIVIDE / QUARTERS);
  localparam int unsigned STD_KHZ = 100;
  localparam int unsigned FAST_KHZ = 400;
  localparam int unsigned REF_MHZ_TABLE [4] = '{100, 75, 50, 33};

  // quarter-phase length for the reference rate code and memory speed grade
  function automatic logic [QW-1:0] quarter_for(input logic [1:0] code, input logic fast);
    int unsigned khz;
    int unsigned ref_khz;
    khz = fast ? FAST_KHZ : STD_KHZ;
    ref_khz = REF_MHZ_TABLE[code] * 1000;
    return QW'((ref_khz + QUARTERS * khz - 1) / (QUARTERS * khz));
  endfunction

  typedef enum logic [6:0] {
    ST_IDLE = 7'h01,
    ST_DEVW = 7'h02,
    ST_WORD = 7'h04,
    ST_DEVR = 7'h08,
    ST_READ = 7'h10,
    ST_DONE = 7'h20,
    ST_FAIL = 7'h40
  } ebl_boot_state_type;

  typedef enum logic [3:0] {
    EN_IDLE = 4'h1,
    EN_START = 4'h2,
    EN_BIT = 4'h4,
    EN_STOP = 4'h8
  } ebl_eng_state_type;

endpackage

// ### ebl_i2c_byte.sv
// two-wire master byte engine: optional start, nine bit slots, optional stop
`timescale 1ns/1ps
`default_nettype none
module ebl_i2c_byte
  import ebl_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [QW-1:0] quarter,
  input wire logic go,
  input wire logic with_start,
  input wire logic with_stop,
  input wire logic is_read,
  input wire logic send_ack,
  input wire logic [7:0] tx_byte,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic scl_oe_n,
  output logic sda_oe_n,
  output logic done,
  output logic nack,
  output logic [7:0] rx_byte
);

  typedef struct packed {
    ebl_eng_state_type st;
    logic [QW-1:0] cnt;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic stop;
    logic rd;
    logic ack;
    logic scl_oe_n;
    logic sda_oe_n;
    logic done;
    logic nack;
    logic park;
  } ebl_eng_type;

  ebl_eng_type q;
  ebl_eng_type d;
  logic tick;
  logic hold;

  // pin levels for a phase; a low enable pulls the wire low
  function automatic logic [1:0] pins(input ebl_eng_type s);
    logic v;
    v = 1'b1;
    if (s.bitn < 4'd8) v = s.rd ? 1'b1 : s.sh[7];
    else v = s.rd ? ~s.ack : 1'b1;
    case (s.st)
      EN_START: pins = (s.ph == 2'd0) ? 2'b01 : (s.ph == 2'd1) ? 2'b11 :
                       (s.ph == 2'd2) ? 2'b10 : 2'b00;
      EN_BIT: pins = {(s.ph == 2'd1) || (s.ph == 2'd2), v};
      EN_STOP: pins = (s.ph == 2'd0) ? 2'b00 : (s.ph == 2'd1) ? 2'b10 : 2'b11;
      // between bytes of one transfer the clock stays low, so no stray pulse
      default: pins = s.park ? 2'b01 : 2'b11;
    endcase
  endfunction

  // a slave that stretches the clock holds the high phase back
  assign hold = (q.st == EN_BIT) && (q.ph == 2'd1) && !scl_i;
  assign tick = (q.cnt == quarter - QW'(1)) && !hold;

  always_comb begin
    d = q;
    d.done = 1'b0;
    // a held clock parks the count at its end until the wire rises
    if (q.st != EN_IDLE) begin
      if (tick) d.cnt = '0;
      else if (!(hold && q.cnt == quarter - QW'(1))) d.cnt = q.cnt + QW'(1);
    end
    case (q.st)
      EN_IDLE: begin
        if (go) begin
          d.st = with_start ? EN_START : EN_BIT;
          d.sh = tx_byte;
          d.rd = is_read;
          d.ack = send_ack;
          d.stop = with_stop;
          d.ph = 2'd0;
          d.bitn = 4'd0;
          d.cnt = '0;
          d.park = 1'b0;
        end
      end
      EN_START: begin
        if (tick) begin
          d.ph = q.ph + 2'd1;
          if (q.ph == 2'd3) d.st = EN_BIT;
        end
      end
      EN_BIT: begin
        if (tick) begin
          d.ph = q.ph + 2'd1;
          if (q.ph == 2'd2) begin
            if (q.bitn < 4'd8 && q.rd) d.sh = {q.sh[6:0], sda_i};
            if (q.bitn == 4'd8 && !q.rd) d.nack = sda_i;
          end
          if (q.ph == 2'd3) begin
            if (q.bitn < 4'd8 && !q.rd) d.sh = {q.sh[6:0], 1'b0};
            d.bitn = q.bitn + 4'd1;
            if (q.bitn == 4'd8) begin
              d.bitn = 4'd0;
              if (q.stop) d.st = EN_STOP;
              else begin
                d.st = EN_IDLE;
                // a refused write lets the bus go, anything else keeps it
                d.park = q.rd || !q.nack;
                d.done = 1'b1;
              end
            end
          end
        end
      end
      EN_STOP: begin
        if (tick) begin
          d.ph = q.ph + 2'd1;
          if (q.ph == 2'd3) begin
            d.st = EN_IDLE;
            d.done = 1'b1;
          end
        end
      end
      default: d.st = EN_IDLE;
    endcase
    {d.scl_oe_n, d.sda_oe_n} = pins(d);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) q <= '{st: EN_IDLE, scl_oe_n: 1'b1, sda_oe_n: 1'b1, default: '0};
    else q <= d;
  end

  assign scl_oe_n = q.scl_oe_n;
  assign sda_oe_n = q.sda_oe_n;
  assign done = q.done;
  assign nack = q.nack;
  assign rx_byte = q.sh;

  // each bit phase ends only once the count reaches one less than the programmed quarter count
  a_phase_length: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == EN_BIT && $past(q.st) == EN_BIT && q.ph != $past(q.ph) && q.bitn == $past(q.bitn)
      && q.cnt == '0) |-> $past(q.cnt) == quarter - QW'(1))
    else $error("bit phase length differs from quarter count");

  // within a bit slot data only changes while the serial clock is low
  a_sda_stable: assert property (@(posedge clk) disable iff (!resetn)
    (q.st == EN_BIT && $past(q.st) == EN_BIT && q.scl_oe_n && $past(q.scl_oe_n))
      |-> $stable(q.sda_oe_n))
    else $error("data line moved while clock high");

endmodule // ebl_i2c_byte
`default_nettype wire

// ### ebl_boot_loader.sv
// system boot loader: reads the serial boot memory and releases the chip
`timescale 1ns/1ps
`default_nettype none
module ebl_boot_loader
  import ebl_pkg::*;
#(
  parameter int unsigned MEM_ADDR_W = 32
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl_i,
  input wire logic sda_i,
  input wire logic host_core_release,
  output logic scl_o,
  output logic scl_oe_n,
  output logic sda_o,
  output logic sda_oe_n,
  output logic main_processor_core_reset_n,
  output logic highway_reset_n,
  output logic units_enable,
  output logic boot_done,
  output logic boot_error,
  output logic autonomous_mode,
  output logic config_valid,
  output logic [19:0] main_memory_interface_config,
  output logic [7:0] clock_ratio_config,
  output logic [15:0] subsystem_id,
  output logic [15:0] subsystem_vendor_id,
  output logic [2:0] dram_aperture_size,
  output logic test_mode,
  output logic [MEM_ADDR_W-1:0] dram_aperture_base,
  output logic [MEM_ADDR_W-1:0] register_io_aperture_base,
  output logic mem_wr_en,
  output logic [MEM_ADDR_W-1:0] mem_wr_addr,
  output logic [7:0] mem_wr_data
);

  if (MEM_ADDR_W < IDX_W || MEM_ADDR_W > 32) begin : g_bad_width
    $error("MEM_ADDR_W must lie between 11 and 32");
  end

  typedef struct packed {
    ebl_boot_state_type st;
    logic [IDX_W-1:0] idx;
    logic [IDX_W-1:0] last;
    logic [IDX_W-1:0] cap;
    logic [QW-1:0] quarter;
    logic first_done;
    logic auto;
    logic [2:0] aper;
    logic test;
    logic [15:0] subsys;
    logic [15:0] vendor;
    logic [19:0] main_memory_interface;
    logic [7:0] pll;
    logic [31:0] dbase;
    logic [31:0] iobase;
    logic [IDX_W-1:0] plen;
    logic cfg_valid;
    logic highway_rel;
    logic core_rel;
    logic units_run;
    logic boot_done;
    logic boot_err;
    logic mem_we;
    logic [MEM_ADDR_W-1:0] mem_addr;
    logic [7:0] mem_data;
    logic go;
    logic c_start;
    logic c_stop;
    logic c_rd;
    logic c_ack;
    logic [7:0] c_tx;
  } ebl_boot_type;

  ebl_boot_type q;
  ebl_boot_type d;
  logic eng_done;
  logic eng_nack;
  logic [7:0] rx;
  logic [IDX_W-1:0] prog_off;
  logic [IDX_W-1:0] prog_last;

  ebl_i2c_byte u_engine (
    .clk(clk),
    .resetn(resetn),
    .quarter(q.quarter),
    .go(q.go),
    .with_start(q.c_start),
    .with_stop(q.c_stop),
    .is_read(q.c_rd),
    .send_ack(q.c_ack),
    .tx_byte(q.c_tx),
    .scl_i(scl_i),
    .sda_i(sda_i),
    .scl_oe_n(scl_oe_n),
    .sda_oe_n(sda_oe_n),
    .done(eng_done),
    .nack(eng_nack),
    .rx_byte(rx)
  );

  assign prog_off = q.idx - IDX_PROG;
  // program end, clipped to the size of the fitted memory
  assign prog_last = ({q.plen[2:0], rx} == 11'h000) ? IDX_PROG :
                     (q.cap - (IDX_PROG - 11'h001) < {q.plen[2:0], rx}) ? q.cap :
                     (IDX_PROG - 11'h001) + {q.plen[2:0], rx};

  always_comb begin
    d = q;
    d.go = 1'b0;
    d.mem_we = 1'b0;
    case (q.st)
      ST_IDLE: begin
        // reset just released: open with start and write address
        d.st = ST_DEVW;
        d.go = 1'b1;
        d.c_start = 1'b1;
        d.c_rd = 1'b0;
        d.c_tx = EE_DEV_WRITE;
      end
      ST_DEVW: begin
        if (eng_done) begin
          d.st = eng_nack ? ST_FAIL : ST_WORD;
          d.go = !eng_nack;
          d.c_start = 1'b0;
          d.c_tx = EE_WORD_START;
        end
      end
      ST_WORD: begin
        if (eng_done) begin
          d.st = eng_nack ? ST_FAIL : ST_DEVR;
          d.go = !eng_nack;
          d.c_start = 1'b1;
          d.c_tx = EE_DEV_READ;
        end
      end
      ST_DEVR: begin
        if (eng_done) begin
          d.st = eng_nack ? ST_FAIL : ST_READ;
          d.go = !eng_nack;
          d.c_start = 1'b0;
          d.c_rd = 1'b1;
          d.c_ack = 1'b1;
          d.c_stop = 1'b0;
        end
      end
      ST_READ: begin
        if (eng_done) begin
          case (q.idx)
            IDX_CFG: begin
              d.first_done = 1'b1;
              d.quarter = quarter_for(rx[CFG_CLK_LSB +: 2], rx[CFG_FAST_BIT]);
              d.cap = rx[CFG_LINES_BIT] ? IDX_CAP_LARGE : IDX_CAP_SMALL;
              d.aper = rx[CFG_APER_LSB +: 3];
              d.test = rx[CFG_TEST_BIT];
            end
            IDX_SUBSYS_HI, IDX_SUBSYS_LO: d.subsys = {q.subsys[7:0], rx};
            IDX_VENDOR_HI, IDX_VENDOR_LO: d.vendor = {q.vendor[7:0], rx};
            IDX_MMI_HI: d.main_memory_interface[19:12] = rx;
            IDX_MMI_MID: d.main_memory_interface[11:4] = rx;
            IDX_MMI_LO: d.main_memory_interface[3:0] = rx[7:4];
            IDX_PLL: d.pll = rx;
            IDX_MODE: begin
              d.auto = rx[MODE_AUTO_BIT];
              // host mode stops after one discarded byte closed with a nack
              if (!rx[MODE_AUTO_BIT]) d.last = IDX_HOST_LAST;
            end
            IDX_LEN_HI: d.plen = {8'h00, rx[2:0]};
            IDX_LEN_LO: begin
              d.plen = {q.plen[2:0], rx};
              d.last = prog_last;
            end
            default: begin
              if (q.auto && q.idx >= IDX_DBASE && q.idx < IDX_IOBASE)
                d.dbase = {q.dbase[23:0], rx};
              else if (q.auto && q.idx >= IDX_IOBASE && q.idx < IDX_LEN_HI)
                d.iobase = {q.iobase[23:0], rx};
            end
          endcase
          if (q.auto && q.idx >= IDX_PROG && prog_off < q.plen) begin
            d.mem_we = 1'b1;
            d.mem_addr = q.dbase[MEM_ADDR_W-1:0] + MEM_ADDR_W'(prog_off);
            d.mem_data = rx;
          end
          if (q.idx == q.last) begin
            d.st = ST_DONE;
            d.boot_done = 1'b1;
            d.cfg_valid = 1'b1;
            d.units_run = 1'b1;
            d.highway_rel = 1'b1;
            d.core_rel = q.auto;
          end else begin
            d.idx = q.idx + 11'h001;
            d.go = 1'b1;
            d.c_ack = (d.idx != d.last);
            d.c_stop = (d.idx == d.last);
          end
        end
      end
      ST_DONE: begin
        if (!q.auto && host_core_release) d.core_rel = 1'b1;
      end
      ST_FAIL: d.boot_err = 1'b1;
      default: d.st = ST_FAIL;
    endcase
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '{st: ST_IDLE, quarter: SLOW_QUARTER, last: IDX_CAP_LARGE,
             cap: IDX_CAP_LARGE, default: '0};
    end else begin
      q <= d;
    end
  end

  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign main_processor_core_reset_n = q.core_rel;
  assign highway_reset_n = q.highway_rel;
  assign units_enable = q.units_run;
  assign boot_done = q.boot_done;
  assign boot_error = q.boot_err;
  assign autonomous_mode = q.auto;
  assign config_valid = q.cfg_valid;
  assign main_memory_interface_config = q.main_memory_interface;
  assign clock_ratio_config = q.pll;
  assign subsystem_id = q.subsys;
  assign subsystem_vendor_id = q.vendor;
  assign dram_aperture_size = q.aper;
  assign test_mode = q.test;
  assign dram_aperture_base = q.dbase[MEM_ADDR_W-1:0];
  assign register_io_aperture_base = q.iobase[MEM_ADDR_W-1:0];
  assign mem_wr_en = q.mem_we;
  assign mem_wr_addr = q.mem_addr;
  assign mem_wr_data = q.mem_data;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  a_units_gated: assert property (!q.boot_done |-> !q.units_run && !q.highway_rel)
    else $error("units enabled before boot finished");

  a_core_held: assert property (!q.boot_done |-> !q.core_rel)
    else $error("core released before boot finished");

  a_config_before_core: assert property ($rose(q.core_rel) |-> q.cfg_valid && $stable(q.main_memory_interface))
    else $error("core released before configuration loaded");

  a_mode_capture: assert property ((q.st == ST_READ && eng_done && q.idx == IDX_MODE)
    |=> q.auto == $past(rx[MODE_AUTO_BIT]))
    else $error("boot mode not taken from tenth byte");

  a_host_no_program: assert property ((q.boot_done && !q.auto) |-> q.idx == IDX_HOST_LAST)
    else $error("host boot read past eleventh byte");

  a_host_no_write: assert property (!q.auto |-> !q.mem_we)
    else $error("host boot wrote main memory");

  a_copy_after_base: assert property ($rose(q.mem_we) |-> q.auto && $past(q.idx) >= IDX_PROG)
    else $error("program copy before apertures set");

  a_auto_release: assert property ($rose(q.boot_done) && q.auto
    |-> q.core_rel && q.highway_rel)
    else $error("autonomous boot did not release core and highway");

  a_host_release: assert property ($rose(q.core_rel) && !q.auto |-> $past(host_core_release))
    else $error("host boot released core without host request");

  a_slow_first: assert property (!q.first_done |-> q.quarter == SLOW_QUARTER)
    else $error("first byte not read at slow rate");

  a_fast_later: assert property ((q.st == ST_READ && eng_done && q.idx == IDX_CFG)
    |=> q.quarter == quarter_for($past(rx[CFG_CLK_LSB +: 2]), $past(rx[CFG_FAST_BIT])))
    else $error("serial rate not updated from first byte");

endmodule // ebl_boot_loader
`default_nettype wire

// ### ebl_eeprom_model.sv
// behavioural two-wire boot memory with optional clock stretching
`timescale 1ns/1ps
`default_nettype none
module ebl_eeprom_model (
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  input wire logic present,
  input wire logic [7:0] stretch,
  output logic sda_pull,
  output logic scl_pull
);
  logic [7:0] mem [2048];
  logic [7:0] sh;
  logic [10:0] ptr;
  logic rw;
  logic mack;
  int bitn;
  int ph;
  int max_ptr;
  initial begin
    sda_pull = 1'b0;
    scl_pull = 1'b0;
    ph = 3;
    bitn = 0;
    max_ptr = -1;
  end
  // start and stop seen only while the clock wire is high
  always @(negedge sda) if (scl === 1'b1) begin
    ph = 0;
    bitn = -1;
    sda_pull = 1'b0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    ph = 3;
    sda_pull = 1'b0;
  end
  always @(posedge scl) if (ph < 3) begin
    if (bitn >= 0 && bitn < 8) sh = {sh[6:0], sda};
    else if (bitn == 8) mack = (sda === 1'b0);
  end
  always @(negedge scl) if (ph < 3) begin
    bitn++;
    if (bitn == 8 && ph == 2) sda_pull = 1'b0;
    else if (bitn == 8) begin
      if (ph == 0) begin
        rw = sh[0];
        if (!present || sh[7:4] != 4'ha) ph = 3;
      end else ptr = {3'h0, sh};
      sda_pull = (ph != 3);
    end else if (bitn == 9) begin
      bitn = 0;
      sda_pull = 1'b0;
      if (ph == 2 && !mack) ph = 3;
      else if (ph == 2) ptr = ptr + 11'h001;
      else if (ph == 1) ph = 3;
      else ph = rw ? 2 : 1;
    end
    if (ph == 2 && bitn >= 0 && bitn < 8) begin
      sda_pull = ~mem[ptr][7 - bitn];
      if (int'(ptr) > max_ptr) max_ptr = int'(ptr);
    end
    // clock wire only held low, never driven as a second master
    if (stretch != 8'h00) begin
      scl_pull = 1'b1;
      repeat (int'(stretch)) @(posedge clk);
      scl_pull = 1'b0;
    end
  end
endmodule // ebl_eeprom_model
`default_nettype wire

// ### ebl_boot_loader_tb_top.sv
// self-checking bench for the boot loader against a behavioural boot memory
`timescale 1ns/1ps
`default_nettype none
module ebl_boot_loader_tb_top;
  import ebl_pkg::*;
  logic clk, resetn, host_core_release, present, scl_prev;
  logic [7:0] stretch, clk_ratio, wr_data;
  logic scl_oe_n, sda_oe_n, scl_o, sda_o, core_n, hw_n, units_en, done, err, auto, cfg_v;
  logic test_m, wr_en, ee_sda, ee_scl;
  logic [19:0] memif_cfg;
  logic [15:0] sub_id, ven_id;
  logic [2:0] ap_size;
  logic [31:0] dbase, iobase, wr_addr, dbase_exp, io_exp;
  logic [31:0] exp_a[$], exp_d[$];
  int rises[$];
  int img[2048];
  int refm[4] = '{100, 75, 50, 33};
  int num_errors, n_checks, cyc, q;
  int unsigned seed_r;
  wire logic scl_w = scl_oe_n & ~ee_scl;
  wire logic sda_w = sda_oe_n & ~ee_sda;

  ebl_boot_loader #(.MEM_ADDR_W(32)) uut (.clk(clk), .resetn(resetn), .scl_i(scl_w),
    .sda_i(sda_w), .host_core_release(host_core_release), .scl_o(scl_o),
    .scl_oe_n(scl_oe_n), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
    .main_processor_core_reset_n(core_n), .highway_reset_n(hw_n), .units_enable(units_en),
    .boot_done(done), .boot_error(err), .autonomous_mode(auto), .config_valid(cfg_v),
    .main_memory_interface_config(memif_cfg), .clock_ratio_config(clk_ratio),
    .subsystem_id(sub_id), .subsystem_vendor_id(ven_id), .dram_aperture_size(ap_size),
    .test_mode(test_m), .dram_aperture_base(dbase), .register_io_aperture_base(iobase),
    .mem_wr_en(wr_en), .mem_wr_addr(wr_addr), .mem_wr_data(wr_data));

  ebl_eeprom_model ee (.clk(clk), .scl(scl_w), .sda(sda_w), .present(present),
    .stretch(stretch), .sda_pull(ee_sda), .scl_pull(ee_scl));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // clock wire rises, memory writes and release order watched every cycle
  always @(negedge clk) begin
    cyc++;
    if (scl_w === 1'b1 && scl_prev !== 1'b1) rises.push_back(cyc);
    scl_prev = scl_w;
    if (wr_en === 1'b1) begin
      if (exp_a.size() == 0) chk("unplanned write", 0, 1);
      else begin
        chk("write addr", exp_a.pop_front(), wr_addr);
        chk("write data", exp_d.pop_front(), wr_data);
        chk("io base at copy", io_exp, iobase);
      end
    end
    if (core_n === 1'b1) chk("config before core", 1, cfg_v);
    if (done !== 1'b1) chk("highway held", 0, hw_n);
    if (done !== 1'b1) chk("units idle", 0, units_en);
  end

  task automatic load_img(input logic [7:0] b0, input logic [7:0] b5, input logic [7:0] b9);
    for (int i = 0; i < 2048; i++) img[i] = $urandom_range(255);
    img[0] = b0;
    img[5] = b5;
    img[9] = b9;
    img[18] = 0;
    img[19] = 8;
    for (int i = 0; i < 2048; i++) ee.mem[i] = 8'(img[i]);
    ee.max_ptr = -1;
  endtask

  task automatic do_reset();
    @(posedge clk);
    resetn <= 1'b0;
    repeat (16) @(posedge clk);
    chk("clock released in reset", 1, scl_oe_n);
    chk("core in reset", 0, core_n);
    rises.delete();
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk("start issued", 0, scl_oe_n);
  endtask

  task automatic wait_end(input int limit);
    int i;
    for (i = 0; i < limit && done !== 1'b1 && err !== 1'b1; i++) @(negedge clk);
    if (i == limit) begin
      num_errors++;
      $display("unexpected boot end: expected done seen none");
      test_done();
    end
    @(negedge clk);
  endtask

  task automatic check_cfg(input logic a);
    chk("memory config", {img[5][7:0], img[6][7:0], img[7][7:4]}, memif_cfg);
    chk("clock ratio", img[8], clk_ratio);
    chk("subsystem", {img[1][7:0], img[2][7:0]}, sub_id);
    chk("vendor", {img[3][7:0], img[4][7:0]}, ven_id);
    chk("aperture size", img[0][6:4], ap_size);
    chk("test mode", img[0][0], test_m);
    chk("mode", a, auto);
    chk("config valid", 1, cfg_v);
    chk("units", 1, units_en);
    chk("highway", 1, hw_n);
    chk("core", a, core_n);
    chk("error", 0, err);
  endtask

  initial begin
    resetn = 1'b0;
    host_core_release = 1'b0;
    present = 1'b0;
    stretch = 8'h00;
    scl_prev = 1'b1;
    num_errors = 0;
    n_checks = 0;
    cyc = 0;
    io_exp = 32'h0000_0000;
    seed_r = $urandom(32'hac8b);
    // absent memory: address refused, chip stays held
    load_img(8'hbe, 8'h06, 8'h00);
    do_reset();
    wait_end(15000);
    chk("refused", 1, err);
    chk("core after refusal", 0, core_n);
    chk("first bit time", 1000, rises[2] - rises[1]);
    repeat (4) @(negedge clk);
    chk("bus released", 2'b11, {scl_oe_n, sda_oe_n});
    // host-assisted boot, 16-bit memory with 8 MB ranks
    present = 1'b1;
    load_img(8'hbe, 8'h0d, 8'h7f);
    do_reset();
    wait_end(60000);
    check_cfg(1'b0);
    chk("host last index", 10, ee.max_ptr);
    q = (refm[img[0][3:2]] * 1000 + 1600 - 1) / 1600;
    chk("fast bit time", 4 * q, rises[rises.size()-2] - rises[rises.size()-3]);
    repeat (20) @(negedge clk);
    chk("core waits for host", 0, core_n);
    @(posedge clk);
    host_core_release <= 1'b1;
    repeat (3) @(negedge clk);
    chk("core by host", 1, core_n);
    // autonomous boot with slow answers, 32 MB ranks on 32-bit memory
    @(posedge clk);
    host_core_release <= 1'b0;
    stretch <= 8'h30;
    load_img(8'h5e, 8'h07, 8'h80);
    dbase_exp = {img[10][7:0], img[11][7:0], img[12][7:0], img[13][7:0]};
    io_exp = {img[14][7:0], img[15][7:0], img[16][7:0], img[17][7:0]};
    for (int i = 0; i < 8; i++) begin
      exp_a.push_back(dbase_exp + 32'(i));
      exp_d.push_back(32'(img[20 + i]));
    end
    do_reset();
    wait_end(70000);
    check_cfg(1'b1);
    chk("dram base", dbase_exp, dbase);
    chk("io base", io_exp, iobase);
    chk("program left", 0, exp_a.size());
    chk("auto last index", 27, ee.max_ptr);
    chk("open drain value", 2'b00, {scl_o, sda_o});
    test_done();
  end
endmodule // ebl_boot_loader_tb_top
`default_nettype wire
